// >>> rtl/pdepc_pkg.sv
// Constants for the port D upper / port E pin control block.
// Assumes a 32-bit APB register bus with byte addresses.
package pdepc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_PD_FSEL  = 8'h78;
  localparam logic [7:0] OFF_PD_DATA  = 8'h7c;
  localparam logic [7:0] OFF_PORT_D_DRIVE_LOW  = 8'h80;
  localparam logic [7:0] OFF_PORT_D_DRIVE_HIGH  = 8'h84;
  localparam logic [7:0] OFF_PORT_D_PULL_LOW = 8'h88;
  localparam logic [7:0] OFF_PORT_D_PULL_HIGH = 8'h8c;
  localparam logic [7:0] OFF_PE_FSEL0 = 8'h90;
  localparam logic [7:0] OFF_PE_FSEL1 = 8'h94;

  // Values after reset
  localparam logic [31:0] RST_PD_FSEL = 32'h0000_7777;
  localparam logic [31:0] RST_PD_DATA = 32'h0000_0000;
  localparam logic [31:0] RST_PORT_D_DRIVE_LOW = 32'h5555_5555;
  localparam logic [31:0] RST_PORT_D_DRIVE_HIGH = 32'h0055_5555;
  localparam logic [31:0] RST_PORTD_BIAS_FIELD = 32'h0000_0000;
  localparam logic [31:0] RST_PE_FSEL = 32'h7777_7777;

  // Writable bits; all others reserved and read zero
  localparam logic [31:0] MSK_PD_FSEL = 32'h0000_7777;
  localparam logic [31:0] MSK_PE_FSEL = 32'h7777_7777;
  localparam logic [31:0] MSK_PD_DATA = 32'h0fff_ffff;
  localparam logic [31:0] MSK_FULL    = 32'hffff_ffff;
  localparam logic [31:0] MSK_HIGH    = 32'h00ff_ffff;

  // Selector codes
  localparam logic [2:0] SEL_INPUT  = 3'h0;
  localparam logic [2:0] SEL_OUTPUT = 3'h1;
  localparam logic [2:0] SEL_FUNC2  = 3'h2;
  localparam logic [2:0] SEL_FUNC3  = 3'h3;
  localparam logic [2:0] SEL_OFF    = 3'h7;

  // Pull codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // Field layout
  localparam int SEL_W     = 3;
  localparam int SEL_PITCH = 4;
  localparam int NPD       = 28;
  localparam int NPD_LOW   = 24;
  localparam int NPD_UP    = 4;
  localparam int NPE       = 16;
  localparam int NPIN      = 20;

  // Pins (D24..D27 then E0..E15) that carry a peripheral code
  localparam logic [19:0] FUNC2_OK = 20'h3_ffff;
  localparam logic [19:0] FUNC3_OK = 20'h3_000f;

endpackage : pdepc_pkg

// >>> rtl/pdepc_sync.sv
// Two-flop level synchroniser for pad inputs.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module pdepc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // Both stages; first one only feeds the second
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } pdepc_sync_type;

  pdepc_sync_type sync_q;
  pdepc_sync_type sync_d;

  // Next stage values
  always_comb
  begin
    sync_d        = sync_q;
    sync_d.stage1 = async_in;
    sync_d.stage2 = sync_q.stage1;
  end

  // Register the chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= '0;
    else
      sync_q <= sync_d;
  end

  assign sync_out = sync_q.stage2;

endmodule : pdepc_sync

`default_nettype wire

// >>> rtl/pdepc_top.sv
// Pin control for port D pins 24..27, port D data/drive/pull, port E 0..15.
// Assumes an APB master on pclk and pads asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module pdepc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Port D pads
  input  wire logic [27:0]       portd_pad_in,
  input  wire logic [23:0]       portd_low_is_input,
  output var  logic [23:0]       portd_low_level_out,
  output var  logic [3:0]        portd_up_pad_out,
  output var  logic [3:0]        portd_up_pad_oe,
  output var  logic [3:0]        portd_up_pad_en,
  output var  logic [55:0]       portd_strength_field,
  output var  logic [27:0]       portd_pull_up_en,
  output var  logic [27:0]       portd_pull_down_en,
  // Port E pads
  input  wire logic [15:0]       porte_pad_in,
  input  wire logic [15:0]       porte_out_level,
  output var  logic [15:0]       porte_pin_level,
  output var  logic [15:0]       porte_pad_out,
  output var  logic [15:0]       porte_pad_oe,
  output var  logic [15:0]       porte_pad_en,
  // Display sources
  input  wire logic              panel_pixel_clock,
  input  wire logic              panel_data_enable,
  input  wire logic              panel_horizontal_sync,
  input  wire logic              panel_vertical_sync,
  input  wire logic              diff_clock_positive,
  input  wire logic              diff_clock_negative,
  input  wire logic              diff_lane3_positive,
  input  wire logic              diff_lane3_negative,
  // Camera
  input  wire logic              cam_master_clock,
  output var  logic              cam_pixel_clock,
  output var  logic              cam_hsync,
  output var  logic              cam_vsync,
  output var  logic [7:0]        cam_data,
  input  wire logic              cam_sio_clock_out,
  input  wire logic              cam_sio_clock_oe,
  input  wire logic              cam_sio_data_out,
  input  wire logic              cam_sio_data_oe,
  output var  logic              cam_sio_clock_in,
  output var  logic              cam_sio_data_in,
  // Third two-wire controller
  input  wire logic              third_twowire_clock_out,
  input  wire logic              third_twowire_clock_oe,
  input  wire logic              third_twowire_data_out,
  input  wire logic              third_twowire_data_oe,
  output var  logic              third_twowire_clock,
  output var  logic              third_twowire_data
);

  // Whole block state
  typedef struct packed {
    logic [31:0] fsel_d;    // Port D upper selectors
    logic [31:0] level;     // Port D data bits
    logic [31:0] drv_lo;    // Drive, pins 0..15
    logic [31:0] drv_hi;    // Drive, pins 16..27
    logic [31:0] pull_lo;   // Pull, pins 0..15
    logic [31:0] pull_hi;   // Pull, pins 16..27
    logic [31:0] fsel_e0;   // Port E selectors 0..7
    logic [31:0] fsel_e1;   // Port E selectors 8..15
    logic [31:0] rdata;     // Read answer
    logic        ready;     // Answer strobe
    logic        err;       // Unmapped access
    logic [19:0] pad_out;   // Pad drive values
    logic [19:0] pad_oe;    // Pad output enables
    logic [19:0] pad_en;    // Pad enables
    logic [55:0] strength;  // Drive levels out
    logic [27:0] pull_up;   // Decoded pull-up
    logic [27:0] pull_dn;   // Decoded pull-down
    logic [15:0] pe_level;  // Port E levels
    logic        cam_pclk;  // Camera pixel clock in
    logic        cam_hs;    // Camera hsync in
    logic        cam_vs;    // Camera vsync in
    logic [7:0]  cam_d;     // Camera data in
    logic        csi_scl;   // Camera serial clock in
    logic        csi_sda;   // Camera serial data in
    logic        tw_scl;    // Two-wire clock in
    logic        tw_sda;    // Two-wire data in
  } pdepc_state_type;

  pdepc_state_type st_q;
  pdepc_state_type st_d;

  logic [43:0]   pad_sync;    // Synchronised pad levels
  logic [79:0]   sel_nib;     // All selector nibbles
  logic [19:0]   pin_data;    // Data bit per pin
  logic [19:0]   f2_out;      // Code 010 drive value
  logic [19:0]   f2_oe;       // Code 010 enable
  logic [19:0]   f3_out;      // Code 011 drive value
  logic [19:0]   f3_oe;       // Code 011 enable
  logic [19:0]   nx_out;      // Next pad value
  logic [19:0]   nx_oe;       // Next pad enable
  logic [19:0]   nx_en;       // Next pad on
  logic [19:0]   is_in;       // Pin set as input
  logic [19:0]   is_f2;       // Pin on code 010
  logic [19:0]   is_f3;       // Pin on code 011
  logic [27:0]   pu_w;        // Pull-up decode
  logic [27:0]   pd_w;        // Pull-down decode
  logic [27:0]   d_in_mask;   // Port D bits read live
  logic [15:0]   e_lvl;       // Port E levels
  logic [31:0]   wmask;       // Byte lanes to bits
  logic [31:0]   rd_val;      // Read mux result
  logic          rd_hit;      // Address mapped
  logic          setup_acc;   // First access cycle
  logic          wr_fire;     // Write completes

  // Pad level synchroniser
  pdepc_sync #(
    .W (44)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({porte_pad_in, portd_pad_in}),
    .sync_out (pad_sync)
  );

  assign e_lvl    = pad_sync[43:28];
  assign sel_nib  = {st_q.fsel_e1, st_q.fsel_e0, st_q.fsel_d[15:0]};
  assign pin_data = {porte_out_level, st_q.level[27:24]};

  // Code 010 sources: panel, camera clock, camera serial
  assign f2_out = {2'b00, cam_sio_data_out, cam_sio_clock_out, 10'h000,
                   cam_master_clock, 1'b0, panel_vertical_sync,
                   panel_horizontal_sync, panel_data_enable,
                   panel_pixel_clock};
  assign f2_oe  = {2'b00, cam_sio_data_oe, cam_sio_clock_oe, 10'h000,
                   1'b1, 1'b0, 4'hf};

  // Code 011 sources: differential pairs, third two-wire
  assign f3_out = {2'b00, third_twowire_data_out, third_twowire_clock_out,
                   12'h000, diff_lane3_negative, diff_lane3_positive,
                   diff_clock_negative, diff_clock_positive};
  assign f3_oe  = {2'b00, third_twowire_data_oe, third_twowire_clock_oe,
                   12'h000, 4'hf};

  // Per pin routing; reserved codes fall to pad off
  for (genvar i = 0; i < pdepc_pkg::NPIN; i++)
  begin : g_pin
    logic [2:0] sel;
    logic       ok2;
    logic       ok3;
    assign sel = sel_nib[pdepc_pkg::SEL_PITCH*i +: pdepc_pkg::SEL_W];
    assign ok2 = pdepc_pkg::FUNC2_OK[i];
    assign ok3 = pdepc_pkg::FUNC3_OK[i];
    assign is_in[i] = (sel == pdepc_pkg::SEL_INPUT);
    assign is_f2[i] = (sel == pdepc_pkg::SEL_FUNC2) && ok2;
    assign is_f3[i] = (sel == pdepc_pkg::SEL_FUNC3) && ok3;

    always_comb
    begin
      nx_out[i] = 1'b0;
      nx_oe[i]  = 1'b0;
      nx_en[i]  = 1'b0;
      case (sel)
        pdepc_pkg::SEL_INPUT:
        begin
          // Receive only
          nx_en[i] = 1'b1;
        end
        pdepc_pkg::SEL_OUTPUT:
        begin
          // Drive the data bit
          nx_en[i]  = 1'b1;
          nx_oe[i]  = 1'b1;
          nx_out[i] = pin_data[i];
        end
        pdepc_pkg::SEL_FUNC2:
        begin
          // First peripheral, if the pin has one
          nx_en[i]  = ok2;
          nx_oe[i]  = ok2 & f2_oe[i];
          nx_out[i] = ok2 & f2_out[i];
        end
        pdepc_pkg::SEL_FUNC3:
        begin
          // Second peripheral, if the pin has one
          nx_en[i]  = ok3;
          nx_oe[i]  = ok3 & f3_oe[i];
          nx_out[i] = ok3 & f3_out[i];
        end
        default:
        begin
          // Pad off, also for reserved codes
          nx_en[i] = 1'b0;
        end
      endcase
    end
  end

  // Pull decode; reserved code gives no pull
  for (genvar p = 0; p < pdepc_pkg::NPD; p++)
  begin : g_pull
    logic [1:0] code;
    if (p < 16)
    begin : g_lo
      assign code = st_q.pull_lo[2*p +: 2];
    end
    else
    begin : g_hi
      assign code = st_q.pull_hi[2*(p-16) +: 2];
    end
    assign pu_w[p] = (code == pdepc_pkg::PULL_UP);
    assign pd_w[p] = (code == pdepc_pkg::PULL_DOWN);
  end

  // Input pins read live levels
  assign d_in_mask = {is_in[3:0], portd_low_is_input};

  // Byte enables to bit mask
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[8*b +: 8] = {8{pstrb[b]}};
  end

  // Register read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = (paddr[1:0] == 2'b00);
    case (paddr[7:0])
      pdepc_pkg::OFF_PD_FSEL:  rd_val = st_q.fsel_d;
      pdepc_pkg::OFF_PD_DATA:
      begin
        // Outputs and peripheral pins read the stored bit
        rd_val = {4'h0, (st_q.level[27:0] & ~d_in_mask)
                       | (pad_sync[27:0] & d_in_mask)};
      end
      pdepc_pkg::OFF_PORT_D_DRIVE_LOW:  rd_val = st_q.drv_lo;
      pdepc_pkg::OFF_PORT_D_DRIVE_HIGH:  rd_val = st_q.drv_hi;
      pdepc_pkg::OFF_PORT_D_PULL_LOW: rd_val = st_q.pull_lo;
      pdepc_pkg::OFF_PORT_D_PULL_HIGH: rd_val = st_q.pull_hi;
      pdepc_pkg::OFF_PE_FSEL0: rd_val = st_q.fsel_e0;
      pdepc_pkg::OFF_PE_FSEL1: rd_val = st_q.fsel_e1;
      default:                 rd_hit = 1'b0;
    endcase
    if (ADDR_W > 8 && (paddr >> 8) != '0)
      rd_hit = 1'b0;
  end

  assign setup_acc = psel & penable & ~st_q.ready;
  assign wr_fire   = psel & penable & st_q.ready & pwrite & rd_hit;

  // Next state
  always_comb
  begin
    st_d = st_q;
    // One wait state, then answer
    st_d.ready = setup_acc;
    st_d.err   = setup_acc & ~rd_hit;
    st_d.rdata = (setup_acc & ~pwrite & rd_hit) ? rd_val : 32'h0000_0000;
    // Stores, masked to writable bits
    if (wr_fire)
    begin
      case (paddr[7:0])
        pdepc_pkg::OFF_PD_FSEL:
          st_d.fsel_d = (st_q.fsel_d & ~wmask)
                      | (pwdata & wmask & pdepc_pkg::MSK_PD_FSEL);
        pdepc_pkg::OFF_PD_DATA:
          st_d.level = (st_q.level & ~wmask)
                     | (pwdata & wmask & pdepc_pkg::MSK_PD_DATA);
        pdepc_pkg::OFF_PORT_D_DRIVE_LOW:
          st_d.drv_lo = (st_q.drv_lo & ~wmask)
                      | (pwdata & wmask & pdepc_pkg::MSK_FULL);
        pdepc_pkg::OFF_PORT_D_DRIVE_HIGH:
          st_d.drv_hi = (st_q.drv_hi & ~wmask)
                      | (pwdata & wmask & pdepc_pkg::MSK_HIGH);
        pdepc_pkg::OFF_PORT_D_PULL_LOW:
          st_d.pull_lo = (st_q.pull_lo & ~wmask)
                       | (pwdata & wmask & pdepc_pkg::MSK_FULL);
        pdepc_pkg::OFF_PORT_D_PULL_HIGH:
          st_d.pull_hi = (st_q.pull_hi & ~wmask)
                       | (pwdata & wmask & pdepc_pkg::MSK_HIGH);
        pdepc_pkg::OFF_PE_FSEL0:
          st_d.fsel_e0 = (st_q.fsel_e0 & ~wmask)
                       | (pwdata & wmask & pdepc_pkg::MSK_PE_FSEL);
        pdepc_pkg::OFF_PE_FSEL1:
          st_d.fsel_e1 = (st_q.fsel_e1 & ~wmask)
                       | (pwdata & wmask & pdepc_pkg::MSK_PE_FSEL);
        default:
          st_d.err = 1'b0;
      endcase
    end
    // Pad side, registered once
    st_d.pad_out  = nx_out;
    st_d.pad_oe   = nx_oe;
    st_d.pad_en   = nx_en;
    st_d.strength = {st_q.drv_hi[23:0], st_q.drv_lo};
    st_d.pull_up  = pu_w;
    st_d.pull_dn  = pd_w;
    st_d.pe_level = e_lvl;
    // Camera inputs, low when not routed
    st_d.cam_pclk = is_f2[4] & e_lvl[0];
    st_d.cam_hs   = is_f2[6] & e_lvl[2];
    st_d.cam_vs   = is_f2[7] & e_lvl[3];
    st_d.cam_d    = is_f2[15:8] & e_lvl[11:4];
    // Serial inputs idle high when not routed
    st_d.csi_scl  = ~is_f2[16] | e_lvl[12];
    st_d.csi_sda  = ~is_f2[17] | e_lvl[13];
    st_d.tw_scl   = ~is_f3[16] | e_lvl[12];
    st_d.tw_sda   = ~is_f3[17] | e_lvl[13];
  end

  // State register with reset values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q         <= '0;
      st_q.fsel_d  <= pdepc_pkg::RST_PD_FSEL;
      st_q.level   <= pdepc_pkg::RST_PD_DATA;
      st_q.drv_lo  <= pdepc_pkg::RST_PORT_D_DRIVE_LOW;
      st_q.drv_hi  <= pdepc_pkg::RST_PORT_D_DRIVE_HIGH;
      st_q.pull_lo <= pdepc_pkg::RST_PORTD_BIAS_FIELD;
      st_q.pull_hi <= pdepc_pkg::RST_PORTD_BIAS_FIELD;
      st_q.fsel_e0 <= pdepc_pkg::RST_PE_FSEL;
      st_q.fsel_e1 <= pdepc_pkg::RST_PE_FSEL;
      st_q.strength <= {pdepc_pkg::RST_PORT_D_DRIVE_HIGH[23:0], pdepc_pkg::RST_PORT_D_DRIVE_LOW};
      st_q.csi_scl <= 1'b1;
      st_q.csi_sda <= 1'b1;
      st_q.tw_scl  <= 1'b1;
      st_q.tw_sda  <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state
  assign prdata               = st_q.rdata;
  assign pready               = st_q.ready;
  assign pslverr              = st_q.err;
  assign portd_low_level_out  = st_q.level[23:0];
  assign portd_up_pad_out     = st_q.pad_out[3:0];
  assign portd_up_pad_oe      = st_q.pad_oe[3:0];
  assign portd_up_pad_en      = st_q.pad_en[3:0];
  assign porte_pad_out        = st_q.pad_out[19:4];
  assign porte_pad_oe         = st_q.pad_oe[19:4];
  assign porte_pad_en         = st_q.pad_en[19:4];
  assign portd_strength_field = st_q.strength;
  assign portd_pull_up_en     = st_q.pull_up;
  assign portd_pull_down_en   = st_q.pull_dn;
  assign porte_pin_level      = st_q.pe_level;
  assign cam_pixel_clock      = st_q.cam_pclk;
  assign cam_hsync            = st_q.cam_hs;
  assign cam_vsync            = st_q.cam_vs;
  assign cam_data             = st_q.cam_d;
  assign cam_sio_clock_in     = st_q.csi_scl;
  assign cam_sio_data_in      = st_q.csi_sda;
  assign third_twowire_clock  = st_q.tw_scl;
  assign third_twowire_data   = st_q.tw_sda;

endmodule : pdepc_top

`default_nettype wire

// >>> tb/pdepc_sva.sv
// Checker for pdepc_top: bus timing, pad enables, reset and write effects.
// Assumes it is bound to every pdepc_top instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module pdepc_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [23:0]       portd_low_level_out,
  input wire logic [3:0]        portd_up_pad_oe,
  input wire logic [3:0]        portd_up_pad_en,
  input wire logic [55:0]       portd_strength_field,
  input wire logic [27:0]       portd_pull_up_en,
  input wire logic [27:0]       portd_pull_down_en,
  input wire logic [15:0]       porte_pad_oe,
  input wire logic [15:0]       porte_pad_en,
  input wire logic              cam_sio_clock_in,
  input wire logic              third_twowire_clock
);
  // One clock domain, reset disables everything
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Answer comes in the second access cycle, for one cycle only
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  // Refused transfer returns zero data
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with nonzero data");
  // Pull up and pull down never together
  a_pull_excl: assert property ((portd_pull_up_en & portd_pull_down_en) == 28'h0)
    else $error("pull up and pull down both enabled");
  // Disabled pad never drives
  a_off_no_drive: assert property (((portd_up_pad_oe & ~portd_up_pad_en) == 4'h0)
    && ((porte_pad_oe & ~porte_pad_en) == 16'h0))
    else $error("disabled pad has output enable");
  // Values seen right after reset release
  a_reset_vals: assert property ($rose(presetn) |-> porte_pad_en == 16'h0
    && portd_strength_field == {24'h55_5555, 32'h5555_5555})
    else $error("wrong pad state after reset");
  // Full data write reaches the low port D levels
  a_data_drive: assert property (pready && pwrite && !pslverr && paddr == 8'h7c
    && pstrb == 4'hf |=> ##1 portd_low_level_out == $past(pwdata[23:0], 2))
    else $error("data write not seen on port D levels");
  // Full drive write reaches the strength field
  a_drive_write: assert property (pready && pwrite && !pslverr && paddr == 8'h80
    && pstrb == 4'hf |=> ##1 portd_strength_field[31:0] == $past(pwdata, 2))
    else $error("drive write not seen on strength field");
  // Unrouted serial inputs idle high
  a_serial_idle: assert property (!porte_pad_en[12] [*4] |-> cam_sio_clock_in
    && third_twowire_clock)
    else $error("unrouted serial clock input not high");
endmodule : pdepc_sva

bind pdepc_top pdepc_sva #(.ADDR_W(ADDR_W)) u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .portd_low_level_out, .portd_up_pad_oe, .portd_up_pad_en, .portd_strength_field,
  .portd_pull_up_en, .portd_pull_down_en, .porte_pad_oe, .porte_pad_en, .cam_sio_clock_in,
  .third_twowire_clock
);

`default_nettype wire

// >>> tb/pdepc_far.sv
// Board side of the pads: resolves D24..D27 and port E pins from device drive and board level; D0..D23 take the board level.
// Assumes the board level is set by the testbench and held while not driven.
`timescale 1ns/1ps
`default_nettype none

module pdepc_far (
  input  wire logic [3:0]  portd_up_pad_out,
  input  wire logic [3:0]  portd_up_pad_oe,
  input  wire logic [15:0] porte_pad_out,
  input  wire logic [15:0] porte_pad_oe,
  input  wire logic [27:0] board_d,
  input  wire logic [15:0] board_e,
  output var  logic [27:0] portd_pad_in,
  output var  logic [15:0] porte_pad_in
);
  // Driven pin shows the device value, else the board level
  always_comb
  begin
    portd_pad_in = {(portd_up_pad_oe & portd_up_pad_out) | (~portd_up_pad_oe & board_d[27:24]),
                    board_d[23:0]};
    porte_pad_in = (porte_pad_oe & porte_pad_out) | (~porte_pad_oe & board_e);
  end
endmodule : pdepc_far

`default_nettype wire

// >>> tb/tb_port_d_e_pin_control.sv
// Testbench for pdepc_top: register map, pad routing and bus errors.
// Assumes the board model pdepc_far and the bound checker pdepc_sva.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_port_d_e_pin_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0]  pstrb = 4'hf;
  logic [27:0] board_d = 28'h0, portd_pad_in, portd_pull_up_en, portd_pull_down_en;
  logic [23:0] portd_low_is_input = 24'h0;
  logic [3:0]  portd_up_pad_out, portd_up_pad_oe, portd_up_pad_en;
  logic [15:0] board_e = 16'h0, porte_pad_in, porte_out_level = 16'h0;
  logic [15:0] porte_pad_out, porte_pad_oe, porte_pad_en, porte_pin_level;
  logic        v_src = 1'b0, oe_src = 1'b0;  // Peripheral source levels
  logic        cam_pixel_clock, cam_sio_data_in, third_twowire_clock;
  logic        cam_hsync, cam_vsync, cam_sio_clock_in, third_twowire_data;
  logic [7:0]  cam_data;
  int          mismatches = 0, n_compared = 0;
  // Reset, write and read-back values, offsets 0x78 upward
  logic [31:0] rst_v [8] = '{32'h7777, 32'h0, 32'h5555_5555, 32'h55_5555, 32'h0, 32'h0,
                             32'h7777_7777, 32'h7777_7777};
  // Pull writes use pull-down only, never the reserved code
  logic [31:0] wr_v [8] = '{'1, '1, '1, '1, 32'haaaa_aaaa, 32'haaaa_aaaa, '1, '1};
  logic [31:0] rb_v [8] = '{32'h7777, 32'h0fff_ffff, '1, 32'h00ff_ffff, 32'haaaa_aaaa,
                            32'h00aa_aaaa, 32'h7777_7777, 32'h7777_7777};

  // Clock at 25 ns period
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  pdepc_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .portd_pad_in, .portd_low_is_input, .portd_low_level_out(),
    .portd_up_pad_out, .portd_up_pad_oe, .portd_up_pad_en, .portd_strength_field(),
    .portd_pull_up_en, .portd_pull_down_en, .porte_pad_in, .porte_out_level,
    .porte_pin_level, .porte_pad_out, .porte_pad_oe, .porte_pad_en,
    .panel_pixel_clock(v_src), .panel_data_enable(v_src), .panel_horizontal_sync(v_src),
    .panel_vertical_sync(v_src), .diff_clock_positive(v_src), .diff_clock_negative(v_src),
    .diff_lane3_positive(v_src), .diff_lane3_negative(~v_src), .cam_master_clock(v_src),
    .cam_pixel_clock, .cam_hsync, .cam_vsync, .cam_data, .cam_sio_clock_out(oe_src),
    .cam_sio_clock_oe(oe_src), .cam_sio_data_out(oe_src), .cam_sio_data_oe(oe_src),
    .cam_sio_clock_in, .cam_sio_data_in, .third_twowire_clock_out(oe_src),
    .third_twowire_clock_oe(oe_src), .third_twowire_data_out(oe_src),
    .third_twowire_data_oe(oe_src), .third_twowire_clock, .third_twowire_data
  );

  pdepc_far u_far (
    .portd_up_pad_out, .portd_up_pad_oe, .porte_pad_out, .porte_pad_oe,
    .board_d, .board_e, .portd_pad_in, .porte_pad_in
  );

  // Counts and verdict, ends the run
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // One bus transfer; result left in r and err, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    if (pready !== 1'b1)
    begin
      mismatches++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read and compare under a mask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    `CHK(r & m, exp)
  endtask : rdchk

  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      rdchk(8'h78 + 8'(4 * i), rst_v[i], '1);
      apb(1'b1, 8'h78 + 8'(4 * i), wr_v[i]);
      rdchk(8'h78 + 8'(4 * i), rb_v[i], '1);
    end
    apb(1'b0, 8'h98, 32'h0);
    `CHK({err, r}, 33'h1_0000_0000)
    // Only byte lane 1 of the low drive register changes
    pstrb <= 4'h2;
    apb(1'b1, 8'h80, 32'h0);
    pstrb <= 4'hf;
    rdchk(8'h80, 32'hffff_00ff, '1);
    `CHK(portd_pull_down_en, 28'hfff_ffff)
    apb(1'b1, 8'h88, 32'h9);
    repeat (2) @(posedge pclk);
    `CHK({portd_pull_up_en, portd_pull_down_en}, {28'h1, 28'hfff_0002})
    // D24 output, D25 input, D26 panel, D27 differential
    portd_low_is_input <= 24'h1;
    apb(1'b1, 8'h78, 32'h3201);
    apb(1'b1, 8'h7c, 32'h0100_0000);
    for (int v = 0; v < 2; v++)
    begin
      v_src <= v[0];
      board_d <= {28{~v[0]}};
      repeat (4) @(posedge pclk);
      `CHK({portd_up_pad_en, portd_up_pad_oe, portd_up_pad_out[0]}, 9'h1fb)
      `CHK(portd_up_pad_out[3:2], {~v[0], v[0]})
      rdchk(8'h7c, v ? 32'h0100_0000 : 32'h0300_0001, 32'hf3ff_ffff);
    end
    // Port E camera, serial, reserved and output pins
    board_e <= 16'h0a5d;
    porte_out_level <= 16'h8000;
    apb(1'b1, 8'h90, 32'h2222_2222);
    apb(1'b1, 8'h94, 32'h1223_2222);
    repeat (4) @(posedge pclk);
    `CHK({cam_data, cam_pixel_clock}, 9'h14b)
    `CHK(porte_pad_en, 16'hbfff)
    `CHK({porte_pad_oe[15], porte_pad_out[15], porte_pad_oe[1], porte_pad_out[1]}, 4'hf)
    `CHK({third_twowire_clock, cam_sio_data_in, porte_pad_oe[13:12]}, 4'h0)
    `CHK({cam_vsync, cam_hsync, third_twowire_data, cam_sio_clock_in}, 4'hf)
    `CHK(porte_pin_level, 16'h8a5f)
    // Serial peripherals drive their routed pads high
    oe_src <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK({third_twowire_clock, cam_sio_data_in, porte_pad_oe[13:12]}, 4'hf)
    `CHK(porte_pad_out[13:12], 2'b11)
    // Reset in mid-run restores pad off
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(8'h94, 32'h7777_7777, '1);
    summarize();
  end
endmodule : tb_port_d_e_pin_control

`default_nettype wire
